// ===== shared/ctid_regs.vh
`ifndef CTID_REGS_VH
`define CTID_REGS_VH
// ==========================================================
// Register offsets (byte addresses, one 32-bit word each).
`define CTID_OFS_BANK_CFG 8'h00
`define CTID_OFS_STATUS 8'h04
`define CTID_OFS_SPACE_TAG 8'h10
`define CTID_OFS_VADDR_LO 8'h18
`define CTID_OFS_VADDR_HI 8'h1c
`define CTID_OFS_ANY_LO 8'h20
`define CTID_OFS_ANY_HI 8'h24
`define CTID_OFS_LEAF_LO 8'h28
`define CTID_OFS_LEAF_HI 8'h2c
`define CTID_OFS_HI_DATA 8'h30
// ==========================================================
// Bank configuration fields.
`define CTID_CFG_WIDE_SCHEME 0
`define CTID_CFG_WIDE_TAG 1
`define CTID_CFG_HYP 2
`define CTID_CFG_MON 3
`define CTID_CFG_SECURE 4
`define CTID_CFG_GRAN64K 5
`define CTID_CFG_VER2 6
`define CTID_CFG_VM_LSB 8
`define CTID_CFG_RESET 32'h00000000
// ==========================================================
// Command kinds.
`define CTID_CMD_TAG 2'h0
`define CTID_CMD_VADDR 2'h1
`define CTID_CMD_ANY 2'h2
`define CTID_CMD_LEAF 2'h3
`endif

// ===== rtl/ctid_queue.v
`timescale 1ns/1ps
// ==========================================================
// Pending operation queue.
module ctid_queue #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset.
  input wire clk_i,
  input wire reset_i,
  // Fill side.
  input wire push_i,
  input wire [WIDTH-1:0] push_data_i,
  output wire full_o,
  // Drain side.
  input wire pop_i,
  output wire [WIDTH-1:0] pop_data_o,
  output wire empty_o,
  output wire [AW:0] count_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;
  assign do_push = push_i && (count != DEPTH[AW:0]);
  assign do_pop = pop_i && (count != {(AW+1){1'b0}});
  assign full_o = (count == DEPTH[AW:0]);
  assign empty_o = (count == {(AW+1){1'b0}});
  assign pop_data_o = mem[rd_ptr];
  assign count_o = count;
  always @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== rtl/ctid_top.v
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
// How it works
// - tag from low bits, width by version.
// - narrow scheme forces upper tag bits zero.
// - by-address removes matching entries, globals included.
// - global entries skip tag compare.
// - extra unlocked entries may also go.
// - secure banks ignore machine tag.
// - hypervisor bank matches hypervisor entries only.
// - match only issuing bank's security domain.
// - 32-bit write zero-extends, upper word ignored.
// - address registers write-only, read zero.
// - wide layout tag, reserved, address fields.
// - 64KB granule ignores address bits 15:12.
// - bit 55 replicates into bits 63:56.
// - narrow scheme zeroes address bits 55:32.
// - narrow layout address, reserved, tag fields.
// - any-tag command matches address and machine tag.
// - narrow any-tag layout reserves bits 11:0.
// - leaf command needs final level entries only.
`include "ctid_regs.vh"
module ctid_top #(
  parameter QDEPTH = 4,
  parameter QAW = 2,
  parameter VM_W = 8
) (
  // Clock and reset.
  input wire CLK_SYS_I,
  input wire RESET_I,
  // Register port.
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // Invalidate command to the TLB.
  output wire CMD_VALID_O,
  input wire CMD_READY_I,
  output wire [1:0] CMD_KIND_O,
  output wire [63:0] CMD_VADDR_O,
  output wire [63:0] CMD_VADDR_MASK_O,
  output wire [15:0] CMD_SPACE_TAG_O,
  output wire [VM_W-1:0] CMD_VM_TAG_O,
  output wire CMD_CHECK_SPACE_TAG_O,
  output wire CMD_CHECK_VM_TAG_O,
  output wire CMD_HYP_ONLY_O,
  output wire CMD_MON_ONLY_O,
  output wire CMD_SECURE_O,
  output wire CMD_LEAF_ONLY_O,
  output wire CMD_INCLUDE_GLOBAL_O,
  // Status.
  output wire PENDING_O,
  output wire DROPPED_O
);
  // ==========================================================
  // Configuration and upper-word staging.
  reg [31:0] bank_cfg;
  reg [31:0] hi_stage;
  reg dropped;
  wire wide_scheme;
  wire wide_tag;
  wire hyp;
  wire mon;
  wire secure;
  wire gran64k;
  wire ver2;
  assign wide_scheme = bank_cfg[`CTID_CFG_WIDE_SCHEME];
  assign wide_tag = bank_cfg[`CTID_CFG_WIDE_TAG];
  assign hyp = bank_cfg[`CTID_CFG_HYP];
  assign mon = bank_cfg[`CTID_CFG_MON];
  assign secure = bank_cfg[`CTID_CFG_SECURE];
  assign gran64k = bank_cfg[`CTID_CFG_GRAN64K];
  assign ver2 = bank_cfg[`CTID_CFG_VER2];
  // ==========================================================
  // Write decode.
  reg cmd_hit;
  reg [1:0] kind;
  reg [63:0] word;
  always @* begin
    cmd_hit = 1'b0;
    kind = `CTID_CMD_TAG;
    word = {32'h00000000, WDATA_I};
    if (WR_I) begin
      case (ADDR_I)
        `CTID_OFS_SPACE_TAG: begin
          cmd_hit = 1'b1;
          kind = `CTID_CMD_TAG;
        end
        `CTID_OFS_VADDR_LO: begin
          cmd_hit = 1'b1;
          kind = `CTID_CMD_VADDR;
        end
        `CTID_OFS_ANY_LO: begin
          cmd_hit = 1'b1;
          kind = `CTID_CMD_ANY;
        end
        `CTID_OFS_LEAF_LO: begin
          cmd_hit = 1'b1;
          kind = `CTID_CMD_LEAF;
        end
        `CTID_OFS_VADDR_HI, `CTID_OFS_ANY_HI, `CTID_OFS_LEAF_HI: begin
          cmd_hit = wide_scheme;
          kind = ADDR_I[5] ? (ADDR_I[3] ? `CTID_CMD_LEAF : `CTID_CMD_ANY) : `CTID_CMD_VADDR;
          word = {WDATA_I, hi_stage};
        end
        default: begin
          cmd_hit = 1'b0;
        end
      endcase
    end
  end
  // ==========================================================
  // Field extraction and match scope.
  reg [15:0] tag;
  reg [63:0] va;
  reg [63:0] mask;
  always @* begin
    tag = 16'h0000;
    va = 64'h0;
    mask = {64{1'b1}};
    if (kind == `CTID_CMD_TAG) begin
      tag = ver2 ? word[15:0] : {8'h00, word[7:0]};
      if (!wide_scheme) begin
        tag[15:8] = 8'h00;
      end
    end else if (wide_scheme) begin
      tag = word[63:48];
      va = {{8{word[43]}}, word[43:0], 12'h000};
    end else begin
      va = {32'h00000000, word[31:12], 12'h000};
      tag = {8'h00, word[7:0]};
    end
    if (kind == `CTID_CMD_ANY || kind == `CTID_CMD_LEAF) begin
      tag = 16'h0000;
    end
    if (kind != `CTID_CMD_TAG && wide_scheme && !wide_tag) begin
      tag[15:8] = 8'h00;
    end
    mask[11:0] = 12'h000;
    if (gran64k) begin
      mask[15:12] = 4'h0;
    end
    if (kind == `CTID_CMD_TAG) begin
      mask = 64'h0;
    end
  end
  wire check_space;
  wire check_vm;
  assign check_space = (kind == `CTID_CMD_TAG || kind == `CTID_CMD_VADDR) && !hyp;
  assign check_vm = !secure && !hyp;
  // Packed pending entry: the TLB may over-invalidate beyond this scope.
  localparam QW = 2 + 64 + 64 + 16 + VM_W + 8;
  wire [QW-1:0] push_data;
  wire [QW-1:0] head;
  wire full;
  wire empty;
  wire [QAW:0] count;
  assign push_data = {kind, va, mask, tag, bank_cfg[`CTID_CFG_VM_LSB +: VM_W],
    check_space, check_vm, hyp, mon, secure,
    (kind == `CTID_CMD_LEAF), (kind != `CTID_CMD_TAG), 1'b0};
  ctid_queue #(.WIDTH(QW), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
    .clk_i(CLK_SYS_I),
    .reset_i(RESET_I),
    .push_i(cmd_hit),
    .push_data_i(push_data),
    .full_o(full),
    .pop_i(CMD_READY_I),
    .pop_data_o(head),
    .empty_o(empty),
    .count_o(count)
  );
  assign CMD_VALID_O = !empty;
  assign CMD_KIND_O = head[QW-1 -: 2];
  assign CMD_VADDR_O = head[QW-3 -: 64];
  assign CMD_VADDR_MASK_O = head[QW-67 -: 64];
  assign CMD_SPACE_TAG_O = head[QW-131 -: 16];
  assign CMD_VM_TAG_O = head[7+VM_W:8];
  assign CMD_CHECK_SPACE_TAG_O = head[7];
  assign CMD_CHECK_VM_TAG_O = head[6];
  assign CMD_HYP_ONLY_O = head[5];
  assign CMD_MON_ONLY_O = head[4];
  assign CMD_SECURE_O = head[3];
  assign CMD_LEAF_ONLY_O = head[2];
  assign CMD_INCLUDE_GLOBAL_O = head[1];
  assign PENDING_O = !empty;
  assign DROPPED_O = dropped;
  // ==========================================================
  // Register writes and reads.
  always @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      bank_cfg <= `CTID_CFG_RESET;
      hi_stage <= 32'h00000000;
      dropped <= 1'b0;
      RDATA_O <= 32'h00000000;
    end else begin
      if (WR_I && ADDR_I == `CTID_OFS_BANK_CFG) begin
        bank_cfg <= WDATA_I;
      end
      if (WR_I && ADDR_I == `CTID_OFS_HI_DATA) begin
        hi_stage <= WDATA_I;
      end
      if (cmd_hit && full) begin
        dropped <= 1'b1;
      end else if (WR_I && ADDR_I == `CTID_OFS_STATUS && WDATA_I[1]) begin
        dropped <= 1'b0;
      end
      RDATA_O <= 32'h00000000;
      if (RD_I) begin
        case (ADDR_I)
          `CTID_OFS_BANK_CFG: begin
            RDATA_O <= bank_cfg;
          end
          `CTID_OFS_STATUS: begin
            RDATA_O <= {{(29-QAW){1'b0}}, count, dropped, !empty};
          end
          default: begin
            RDATA_O <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

// ===== sim/ctid_assertions.sv
`timescale 1ns/1ps
`include "ctid_regs.vh"
// ==========================================================
// Command output checks.
module ctid_checker (
  // Clock and reset.
  input logic CLK_SYS_I,
  input logic RESET_I,
  // Register port.
  input logic [7:0] ADDR_I,
  input logic WR_I,
  input logic RD_I,
  input logic [31:0] RDATA_O,
  // Command and status.
  input logic CMD_VALID_O,
  input logic [1:0] CMD_KIND_O,
  input logic [63:0] CMD_VADDR_O,
  input logic [63:0] CMD_VADDR_MASK_O,
  input logic CMD_CHECK_SPACE_TAG_O,
  input logic CMD_CHECK_VM_TAG_O,
  input logic CMD_HYP_ONLY_O,
  input logic CMD_SECURE_O,
  input logic CMD_LEAF_ONLY_O,
  input logic CMD_INCLUDE_GLOBAL_O,
  input logic PENDING_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RESET_I);
  AST_RD_ZERO:
    assert property (RD_I && ADDR_I inside {[8'h10:8'h2c]} |=> RDATA_O == 32'h0)
    else $error("command register read not zero");
  AST_TAKEN:
    assert property (WR_I && ADDR_I == `CTID_OFS_SPACE_TAG && !PENDING_O |=> CMD_VALID_O)
    else $error("write not queued");
  AST_PEND:
    assert property (PENDING_O == CMD_VALID_O) else $error("pending differs");
  AST_SIGN:
    assert property (CMD_VALID_O |-> CMD_VADDR_O[63:56] == {8{CMD_VADDR_O[55]}})
    else $error("address not sign extended");
  AST_MASK:
    assert property (CMD_VALID_O |-> CMD_VADDR_MASK_O[11:0] == 12'h0) else $error("mask low");
  AST_GLOBAL:
    assert property (CMD_VALID_O && CMD_KIND_O == `CTID_CMD_VADDR && !CMD_HYP_ONLY_O
      |-> CMD_INCLUDE_GLOBAL_O) else $error("globals left out");
  AST_ANY:
    assert property (CMD_VALID_O && CMD_KIND_O[1]
      |-> !CMD_CHECK_SPACE_TAG_O && CMD_INCLUDE_GLOBAL_O) else $error("any tag matching");
  AST_LEAF:
    assert property (CMD_VALID_O |-> CMD_LEAF_ONLY_O == (CMD_KIND_O == `CTID_CMD_LEAF))
    else $error("leaf flag wrong");
  AST_HYP:
    assert property (CMD_VALID_O && CMD_HYP_ONLY_O
      |-> !CMD_CHECK_VM_TAG_O && !CMD_CHECK_SPACE_TAG_O) else $error("hypervisor tags");
  AST_SEC:
    assert property (CMD_VALID_O && CMD_SECURE_O |-> !CMD_CHECK_VM_TAG_O)
    else $error("secure machine tag");
endmodule
bind ctid_top ctid_checker u_chk (.*);

// ===== sim/ctid_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench.
module ctid_tb_top;
  logic clk = 0, rst = 1, we = 0, re = 0, rdy = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0;
  wire [31:0] rdata;
  wire [63:0] va, mask;
  wire [15:0] tag;
  wire [7:0] vm;
  wire [1:0] kind;
  wire valid, pend, drop, csp, cvm, hyp, mon, sec, leaf, glb;
  int fails = 0, total_checks = 0, i;
  logic [31:0] cfg_exp = 0;
  always #50 clk = ~clk;
  ctid_top #(.QDEPTH(4), .QAW(2), .VM_W(8)) uut (.CLK_SYS_I(clk), .RESET_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(we), .RD_I(re), .RDATA_O(rdata),
    .CMD_VALID_O(valid), .CMD_READY_I(rdy), .CMD_KIND_O(kind), .CMD_VADDR_O(va),
    .CMD_VADDR_MASK_O(mask), .CMD_SPACE_TAG_O(tag), .CMD_VM_TAG_O(vm),
    .CMD_CHECK_SPACE_TAG_O(csp), .CMD_CHECK_VM_TAG_O(cvm), .CMD_HYP_ONLY_O(hyp),
    .CMD_MON_ONLY_O(mon), .CMD_SECURE_O(sec), .CMD_LEAF_ONLY_O(leaf),
    .CMD_INCLUDE_GLOBAL_O(glb), .PENDING_O(pend), .DROPPED_O(drop));
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task put(input logic [7:0] a, input logic [31:0] d);
    if (a == 8'h00) cfg_exp = d;
    @(posedge clk);
    we <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 0;
  endtask
  task get(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    re <= 1;
    addr <= a;
    @(posedge clk);
    re <= 0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask
  task pop(input logic [1:0] k, input logic [63:0] v, m, input logic [15:0] t,
    input logic [5:0] f, c);
    int n;
    @(negedge clk);
    for (n = 0; n < 8 && valid !== 1'b1; n++) @(negedge clk);
    chk("valid", 1, valid);
    if (valid !== 1'b1) complete_run;
    chk("kind", k, kind);
    if (k != 2'h0) chk("vaddr", v, va);
    chk("mask", m, mask);
    if (f[5]) chk("tag", t, tag);
    chk("flags", f & c, {csp, cvm, hyp, sec, leaf, glb} & c);
    chk("vm", cfg_exp[15:8], vm);
    chk("mon", cfg_exp[3], mon);
    @(posedge clk);
    rdy <= 1;
    @(posedge clk);
    rdy <= 0;
  endtask
  task t_tag;
    put(8'h00, 32'h40);
    put(8'h10, 32'habcd1234);
    pop(2'h0, 0, 0, 16'h0034, 6'h30, 6'h3f);
    put(8'h00, 32'h43);
    put(8'h10, 32'hffff1234);
    pop(2'h0, 0, 0, 16'h1234, 6'h30, 6'h3f);
    put(8'h00, 32'h41);
    put(8'h10, 32'h00000056);
    pop(2'h0, 0, 0, 16'h0056, 6'h30, 6'h3f);
  endtask
  task t_wide;
    put(8'h00, 32'h5a03);
    put(8'h30, 32'h89abcdef);
    put(8'h1c, 32'hbeeff923);
    pop(2'h1, 64'hff92389abcdef000, 64'hfffffffffffff000, 16'hbeef, 6'h31, 6'h3f);
    put(8'h00, 32'h5a23);
    put(8'h18, 32'h0001f000);
    pop(2'h1, 64'h1f000000, 64'hffffffffffff0000, 16'h0, 6'h31, 6'h3f);
  endtask
  task t_narrow;
    put(8'h00, 32'h5a40);
    put(8'h1c, 32'hffffffff);
    @(negedge clk);
    chk("pending", 0, pend);
    put(8'h18, 32'h87654abc);
    pop(2'h1, 64'h87654000, 64'hfffffffffffff000, 16'h00bc, 6'h31, 6'h3f);
    put(8'h20, 32'h12345fff);
    pop(2'h2, 64'h12345000, 64'hfffffffffffff000, 0, 6'h11, 6'h3f);
  endtask
  task t_any;
    put(8'h00, 32'h5a03);
    for (i = 0; i < 2; i++) begin
      put(8'h30, 32'h1000);
      put(8'h24 + 8 * i, 32'h12340000);
      pop(2'h2 + i, 64'h1000000, 64'hfffffffffffff000, 0, 6'h11 | 2 * i, 6'h3f);
    end
  endtask
  task t_bank;
    put(8'h00, 32'h5a0f);
    put(8'h18, 32'h1);
    pop(2'h1, 64'h1000, 64'hfffffffffffff000, 0, 6'h08, 6'h3e);
    put(8'h00, 32'h5a13);
    put(8'h18, 32'h00120002);
    pop(2'h1, 64'h120002000, 64'hfffffffffffff000, 16'h0, 6'h25, 6'h3f);
  endtask
  task t_queue;
    put(8'h00, 32'h43);
    for (i = 0; i < 5; i++) put(8'h10, i);
    @(negedge clk);
    chk("dropped", 1, drop);
    for (i = 0; i < 4; i++) pop(2'h0, 0, 0, i, 6'h30, 6'h3f);
    @(negedge clk);
    chk("pending", 0, pend);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_tag();
    t_wide();
    t_narrow();
    t_any();
    t_bank();
    for (i = 8'h10; i <= 8'h2c; i += 4) get(i, 0);
    get(8'hfc, 0);
    t_queue();
    get(8'h00, 32'h43);
    get(8'h04, 32'h2);
    put(8'h04, 32'h2);
    get(8'h04, 0);
    complete_run();
  end
endmodule
